/* hdl/term_select_pkg.sv */
package term_select_pkg;

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] FUNC_CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] OTG_CTRL_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] TERM_STATUS_ADDR = 4'h8;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SPEED_LSB = 0;
  localparam int TERM_BIT = 2;
  localparam int OPERATING_MODE_CODE_LSB = 3;
  localparam int DPLUS_PD_BIT = 1;
  localparam int DMINUS_PD_BIT = 2;

  // ------------------------------------------------------------
  // Field encodings
  // ------------------------------------------------------------
  localparam logic [1:0] SPEED_HS = 2'h0;
  localparam logic [1:0] SPEED_FS = 2'h1;
  localparam logic [1:0] SPEED_LS = 2'h2;
  localparam logic [1:0] SPEED_FS_LS = 2'h3;
  localparam logic [1:0] OPERATING_MODE_CODE_NORMAL = 2'h0;
  localparam logic [1:0] OPERATING_MODE_CODE_TRISTATE = 2'h1;
  localparam logic [1:0] OPERATING_MODE_CODE_NO_STUFF = 2'h2;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic [1:0] SPEED_RESET = 2'h1;
  localparam logic TERM_RESET = 1'b0;
  localparam logic [1:0] OPERATING_MODE_CODE_RESET = 2'h0;
  localparam logic DPLUS_PD_RESET = 1'b1;
  localparam logic DMINUS_PD_RESET = 1'b1;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] transceiver_speed_select;
    logic termination_select;
    logic [1:0] operating_mode_code;
    logic dplus_pulldown_request;
    logic dminus_pulldown_request;
  } term_ctrl_t;

  typedef struct packed {
    logic hs_termination_enable;
    logic dminus_pulldown_enable;
    logic dplus_pulldown_enable;
    logic dminus_pullup_enable;
    logic dplus_pullup_enable;
  } res_en_t;

  localparam term_ctrl_t CTRL_RESET = '{
    transceiver_speed_select: SPEED_RESET,
    termination_select: TERM_RESET,
    operating_mode_code: OPERATING_MODE_CODE_RESET,
    dplus_pulldown_request: DPLUS_PD_RESET,
    dminus_pulldown_request: DMINUS_PD_RESET
  };

  localparam res_en_t RES_ALL_OFF = 5'h00;

endpackage

/* hdl/usb_termination_select_decoder.sv */
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module usb_termination_select_decoder
  import term_select_pkg::*;
(
  input wire logic clock_i, // 25 MHz clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic [term_select_pkg::ADDR_W-1:0] addr_i, // Byte address
  input wire logic [term_select_pkg::DATA_W-1:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [term_select_pkg::DATA_W-1:0] rdata_o, // Read data
  output term_select_pkg::res_en_t res_en_o // Resistor enables
);

  import term_select_pkg::*;

  // ------------------------------------------------------------
  // Termination decode
  // ------------------------------------------------------------
  function automatic res_en_t decode_term(input term_ctrl_t c);
    res_en_t r;
    logic hs;
    logic fs;
    logic ls;
    logic norm;
    logic nost;
    logic hostpd;
    logic nopd;
    logic otgpd;
    r = RES_ALL_OFF;
    hs = (c.transceiver_speed_select == SPEED_HS);
    fs = (c.transceiver_speed_select == SPEED_FS);
    ls = (c.transceiver_speed_select == SPEED_LS);
    norm = (c.operating_mode_code == OPERATING_MODE_CODE_NORMAL);
    nost = (c.operating_mode_code == OPERATING_MODE_CODE_NO_STUFF);
    hostpd = c.dplus_pulldown_request & c.dminus_pulldown_request;
    nopd = !c.dplus_pulldown_request && !c.dminus_pulldown_request;
    otgpd = !c.dplus_pulldown_request && c.dminus_pulldown_request;
    if (c.operating_mode_code == OPERATING_MODE_CODE_TRISTATE) begin
      r = RES_ALL_OFF;
    end else if (hostpd) begin
      // Host side: both pull-downs, HS termination in HS modes
      if (hs && !c.termination_select && (norm || nost)) begin
        r.dplus_pulldown_enable = 1'b1;
        r.dminus_pulldown_enable = 1'b1;
        r.hs_termination_enable = 1'b1;
      end else if (fs && !c.termination_select && norm) begin
        r.dplus_pulldown_enable = 1'b1;
        r.dminus_pulldown_enable = 1'b1;
      end else if (c.termination_select && (norm || nost)
                   && (fs || ls || c.transceiver_speed_select
                       == SPEED_FS_LS && norm)) begin
        r.dplus_pulldown_enable = 1'b1;
        r.dminus_pulldown_enable = 1'b1;
      end
    end else if (nopd || otgpd) begin
      // Peripheral side, OTG adds the D- pull-down to the D+ pull-up or HS termination
      if (hs && c.termination_select && nost) begin
        r.dplus_pullup_enable = 1'b1;
      end else if (hs && !c.termination_select && (norm || nost)) begin
        r.hs_termination_enable = 1'b1;
      end else if (fs && c.termination_select && (norm || nost)) begin
        r.dplus_pullup_enable = 1'b1;
      end else if (ls && c.termination_select && (norm || nost)
                   && nopd) begin
        r.dminus_pullup_enable = 1'b1;
      end
      if (otgpd && (r.dplus_pullup_enable || r.hs_termination_enable)) begin
        r.dminus_pulldown_enable = 1'b1;
      end
    end
    // Undefined combinations fall through to all off
    // No upstream hub port row exists
    return r;
  endfunction

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  term_ctrl_t ctrl_q;
  term_ctrl_t ctrl_d;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_i && addr_i == FUNC_CTRL_ADDR) begin
      ctrl_d.transceiver_speed_select = wdata_i[SPEED_LSB +: 2];
      ctrl_d.termination_select = wdata_i[TERM_BIT];
      ctrl_d.operating_mode_code = wdata_i[OPERATING_MODE_CODE_LSB +: 2];
    end
    if (wr_i && addr_i == OTG_CTRL_ADDR) begin
      ctrl_d.dplus_pulldown_request = wdata_i[DPLUS_PD_BIT];
      ctrl_d.dminus_pulldown_request = wdata_i[DMINUS_PD_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ------------------------------------------------------------
  // Resistor enables
  // ------------------------------------------------------------
  res_en_t res_en_d;

  always_comb begin
    res_en_d = decode_term(ctrl_q);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      res_en_o <= RES_ALL_OFF;
    end else begin
      res_en_o <= res_en_d;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [DATA_W-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    if (rd_i) begin
      unique case (addr_i)
        FUNC_CTRL_ADDR: begin
          rdata_d[SPEED_LSB +: 2] = ctrl_q.transceiver_speed_select;
          rdata_d[TERM_BIT] = ctrl_q.termination_select;
          rdata_d[OPERATING_MODE_CODE_LSB +: 2] = ctrl_q.operating_mode_code;
        end
        OTG_CTRL_ADDR: begin
          rdata_d[DPLUS_PD_BIT] = ctrl_q.dplus_pulldown_request;
          rdata_d[DMINUS_PD_BIT] = ctrl_q.dminus_pulldown_request;
        end
        TERM_STATUS_ADDR: begin
          rdata_d[4:0] = res_en_o;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  logic past_valid_q;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      past_valid_q <= 1'b0;
    end else begin
      past_valid_q <= 1'b1;
    end
  end

  a_undefined_all_off: assert property (
    ctrl_q.operating_mode_code == 2'h3 |=> res_en_o == RES_ALL_OFF)
    else $error("undefined mode left a resistor on");

  a_otg_chirp_row: assert property (
    ctrl_q == 7'b00_1_10_01 |=> res_en_o == 5'b01001)
    else $error("OTG chirp enables wrong");

  a_otg_hs_row: assert property (
    ctrl_q == 7'b00_0_00_01 |=> res_en_o == 5'b11000)
    else $error("OTG HS enables wrong");

  a_otg_fs_rows: assert property (
    (ctrl_q == 7'b01_1_00_01 || ctrl_q == 7'b01_1_10_01)
    |=> res_en_o == 5'b01001)
    else $error("OTG FS enables wrong");

  a_otg_test_row: assert property (
    ctrl_q == 7'b00_0_10_01 |=> res_en_o == 5'b11000)
    else $error("OTG test enables wrong");

  a_periph_test_row: assert property (
    ctrl_q == 7'b00_0_10_00 |=> res_en_o == 5'b10000)
    else $error("peripheral test enables wrong");

  a_no_dual_pullup: assert property (
    !(res_en_o.dplus_pullup_enable && res_en_o.dminus_pullup_enable))
    else $error("both pull-ups on");

  a_dplus_pullup_excl: assert property (
    res_en_o.dplus_pullup_enable |->
    !res_en_o.dplus_pulldown_enable && !res_en_o.hs_termination_enable)
    else $error("D+ pull-up with conflicting load");

  a_hs_term_speed: assert property (
    res_en_o.hs_termination_enable |->
    $past(ctrl_q.transceiver_speed_select) == SPEED_HS
    && !$past(ctrl_q.termination_select))
    else $error("HS termination outside HS select");

  a_write_takes_effect: assert property (
    wr_i && addr_i == FUNC_CTRL_ADDR && wdata_i[OPERATING_MODE_CODE_LSB +: 2] == 2'h3
    |-> ##2 res_en_o == RES_ALL_OFF)
    else $error("write did not reach enables in time");

  a_status_readback: assert property (
    past_valid_q && $past(rd_i) && $past(addr_i) == TERM_STATUS_ADDR
    |-> rdata_o[4:0] == $past(res_en_o) && rdata_o[7:5] == 3'h0)
    else $error("status read mismatch");

  a_tristate_off: assert property (
    ctrl_q.operating_mode_code == OPERATING_MODE_CODE_TRISTATE |=> res_en_o == RES_ALL_OFF)
    else $error("tri-state mode left a resistor on");

  a_dplus_only_off: assert property (
    ctrl_q.dplus_pulldown_request && !ctrl_q.dminus_pulldown_request
    |=> res_en_o == RES_ALL_OFF)
    else $error("lone D+ pull-down request left a resistor on");

  a_power_up_row: assert property (
    ctrl_q == 7'b01_0_00_11 |=> res_en_o == 5'b01100)
    else $error("power-up enables wrong");

  a_host_hs_rows: assert property (
    (ctrl_q == 7'b00_0_00_11 || ctrl_q == 7'b00_0_10_11)
    |=> res_en_o == 5'b11100)
    else $error("host HS enables wrong");

  a_host_fs_rows: assert property (
    (ctrl_q == 7'b01_1_00_11 || ctrl_q == 7'b11_1_00_11
     || ctrl_q == 7'b01_1_10_11) |=> res_en_o == 5'b01100)
    else $error("host FS enables wrong");

  a_host_ls_rows: assert property (
    (ctrl_q == 7'b10_1_00_11 || ctrl_q == 7'b10_1_10_11)
    |=> res_en_o == 5'b01100)
    else $error("host LS enables wrong");

  a_periph_chirp_row: assert property (
    ctrl_q == 7'b00_1_10_00 |=> res_en_o == 5'b00001)
    else $error("peripheral chirp enables wrong");

  a_periph_hs_row: assert property (
    ctrl_q == 7'b00_0_00_00 |=> res_en_o == 5'b10000)
    else $error("peripheral HS enables wrong");

  a_periph_fs_rows: assert property (
    (ctrl_q == 7'b01_1_00_00 || ctrl_q == 7'b01_1_10_00)
    |=> res_en_o == 5'b00001)
    else $error("peripheral FS enables wrong");

  a_periph_ls_rows: assert property (
    (ctrl_q == 7'b10_1_00_00 || ctrl_q == 7'b10_1_10_00)
    |=> res_en_o == 5'b00010)
    else $error("peripheral LS enables wrong");

  a_otg_ls_off: assert property (
    (ctrl_q == 7'b10_1_00_01 || ctrl_q == 7'b10_1_10_01)
    |=> res_en_o == RES_ALL_OFF)
    else $error("OTG LS left a resistor on");

  a_otg_pd_write: assert property (
    wr_i && addr_i == OTG_CTRL_ADDR |=>
    ctrl_q.dplus_pulldown_request == $past(wdata_i[DPLUS_PD_BIT])
    && ctrl_q.dminus_pulldown_request == $past(wdata_i[DMINUS_PD_BIT]))
    else $error("pull-down request write lost");

  a_func_write: assert property (
    wr_i && addr_i == FUNC_CTRL_ADDR |=>
    ctrl_q.transceiver_speed_select == $past(wdata_i[1:0])
    && ctrl_q.termination_select == $past(wdata_i[2])
    && ctrl_q.operating_mode_code == $past(wdata_i[4:3]))
    else $error("function control write lost");

  c_otg_chirp: cover property (res_en_o == 5'b01001);
  c_periph_ls: cover property (res_en_o == 5'b00010);
  c_host_hs: cover property (res_en_o == 5'b11100);
  c_back_to_back: cover property (wr_i ##1 rd_i ##1 wr_i);

endmodule

`default_nettype wire

/* tb/link_model.sv */
`timescale 1ns/1ps
`default_nettype none

module link_model
  import term_select_pkg::*;
(
  input wire logic clock_i, // Bus clock
  output var logic [term_select_pkg::ADDR_W-1:0] addr_o, // Address
  output var logic [term_select_pkg::DATA_W-1:0] wdata_o, // Write data
  output var logic wr_o, // Write strobe
  output var logic rd_o, // Read strobe
  input wire logic [term_select_pkg::DATA_W-1:0] rdata_i // Read data
);
  initial begin
    addr_o = '0;
    wdata_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // Released lines show the inverse so stale values never match by luck
  task automatic wr_reg(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule

`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  import term_select_pkg::*;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic wr;
  logic rd;
  res_en_t res_en;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;

  always #20 clock_i = ~clock_i;

  usb_termination_select_decoder u_usb_termination_select_decoder (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .res_en_o(res_en));

  link_model u_link_model (
    .clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .rd_o(rd), .rdata_i(rdata));

  // --------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      summarize();
    end
  end

  // Enables {hs, dm_pd, dp_pd, dm_pu, dp_pu} from the signalling table
  function automatic logic [4:0] exp_en(logic [1:0] sp, logic t,
                                        logic [1:0] op, logic dp, logic dm);
    logic ok;
    ok = op[0] == 1'b0;
    if (!ok) begin
      return 5'h00;
    end
    if (dp && dm) begin
      if (sp == 2'h0 && !t) return 5'h1c;
      if (sp[0] && t && op == 2'h0) return 5'h0c;
      if (sp == 2'h1 && (t || op == 2'h0)) return 5'h0c;
      if (sp == 2'h2 && t) return 5'h0c;
      return 5'h00;
    end
    if (dp) return 5'h00;
    if (sp == 2'h0 && t && op == 2'h2) return {1'b0, dm, 3'h1};
    if (sp == 2'h0 && !t) return {1'b1, dm, 3'h0};
    if (sp == 2'h1 && t) return {1'b0, dm, 3'h1};
    if (sp == 2'h2 && t && !dm) return 5'h02;
    return 5'h00;
  endfunction

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic test_reset();
    logic [7:0] d;
    chk({3'h0, res_en}, 8'h00);
    @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk({3'h0, res_en}, 8'h0c);
    u_link_model.rd_reg(FUNC_CTRL_ADDR, d);
    chk(d, 8'h01);
    u_link_model.rd_reg(OTG_CTRL_ADDR, d);
    chk(d, 8'h06);
    $display("test reset done");
  endtask

  task automatic test_all_combos();
    logic [7:0] d;
    logic [4:0] e;
    for (int i = 0; i < 128; i++) begin
      e = exp_en(i[1:0], i[2], i[4:3], i[5], i[6]);
      u_link_model.wr_reg(OTG_CTRL_ADDR, {5'h0, i[6], i[5], 1'b0});
      u_link_model.wr_reg(FUNC_CTRL_ADDR, {3'h0, i[4:0]});
      @(posedge clock_i);
      #1;
      chk({3'h0, res_en}, {3'h0, e});
      u_link_model.rd_reg(TERM_STATUS_ADDR, d);
      chk(d, {3'h0, e});
      u_link_model.rd_reg(FUNC_CTRL_ADDR, d);
      chk(d, {3'h0, i[4:0]});
    end
    $display("test all combinations done");
  endtask

  task automatic test_unmapped();
    logic [7:0] d;
    u_link_model.wr_reg(4'hc, 8'h00);
    u_link_model.rd_reg(4'hc, d);
    chk(d, 8'h00);
    u_link_model.rd_reg(FUNC_CTRL_ADDR, d);
    chk(d, 8'h1f);
    @(posedge clock_i);
    #1;
    chk(rdata, 8'h00);
    u_link_model.rd_reg(OTG_CTRL_ADDR, d);
    chk(d, 8'h06);
    $display("test unmapped done");
  endtask

  initial begin
    repeat (9) @(posedge clock_i);
    test_reset();
    test_all_combos();
    test_unmapped();
    summarize();
  end
endmodule

`default_nettype wire
